// ==== hdl/fsbc_top.sv ====
// Flash array with security byte, programmer port and core fetch port.
// Assumes programmer pins arrive asynchronous; core port is on CLK_SYS.
//
// What this block does
// - Flash of 128 or 256 pages, 128 bytes
// - Programming a byte or page self-erases first
// - Erase-and-program completes in about 10 ms
// - Byte reads return with no wait state
// - Access pin low fetches from external memory
// - Security byte reached only by parallel programmer
// - Programmed bit 7 selects double speed
// - Programmed bit 6 boots loader at F800h
// - Programmed bit 3 inhibits expanded RAM
// - Shipped byte: loader, standard speed, level four
// - RAM and lock bits only programmer-changeable
// - All lock bits unprogrammed means level 1
// - Level 2 blocks table reads from external code, programming; latches pin
// - Level 3 also refuses parallel verify reads
// - Level 4 also disables external execution
// - Lock bits govern programmer and core, never the API
// - Chip erase clears array and security byte
// - Part identification always readable
`timescale 1ns/100ps
module fsbc_top #(
    parameter int PAGES = fsbc_pkg::PAGES_32K,
    parameter int PROG_CYCLES = fsbc_pkg::PROG_CYCLES,
    parameter logic [7:0] PART_ID = fsbc_pkg::PART_ID_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic EXT_ACCESS_N,
    input wire logic [2:0] PROG_CMD,
    input wire logic PROG_STROBE,
    input wire logic [14:0] PROG_ADDR,
    input wire logic [7:0] PROG_WDATA,
    output logic [7:0] PROG_RDATA,
    output logic PROG_BUSY,
    output logic PROG_REFUSED,
    input wire logic CORE_RD,
    input wire logic CORE_TABLE_READ,
    input wire logic CORE_FROM_EXT,
    input wire logic [15:0] CORE_ADDR,
    output logic [7:0] CORE_RDATA,
    output logic CORE_FETCH_EXT,
    output logic CORE_BLOCKED,
    input wire logic API_WR,
    input wire logic API_PAGE,
    input wire logic [14:0] API_ADDR,
    input wire logic [7:0] API_WDATA,
    output logic API_BUSY,
    output logic DOUBLE_SPEED,
    output logic [15:0] BOOT_ADDR,
    output logic EXPANDED_RAM_INHIBIT,
    output logic [2:0] SECURITY_LEVEL
);
    localparam int BYTES = PAGES * fsbc_pkg::PAGE_BYTES;
    localparam int AW = $clog2(BYTES);
    localparam logic [fsbc_pkg::TIMER_W-1:0] PROG_LOAD = fsbc_pkg::TIMER_W'(PROG_CYCLES - 1);

    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        fsbc_pkg::fsbc_state_type state;
        logic [fsbc_pkg::TIMER_W-1:0] timer;
        logic [2:0] cmd_meta;
        logic [2:0] cmd_sync;
        logic [2:0] strb_meta;
        logic [2:0] ea_meta;
        logic strb_last;
        logic [7:0] hardware_security_config_byte;
        logic [7:0] hsb_pending;
        fsbc_pkg::fsbc_cfg_type cfg;
        logic ea_latched;
        logic sampled;
        logic [AW-1:0] tgt_addr;
        logic [7:0] tgt_data;
        logic tgt_page;
        logic tgt_chip;
        logic tgt_hsb;
        logic [7:0] prog_rdata;
        logic refused;
        logic [7:0] core_rdata;
        logic blocked;
    } fsbc_state_rec_type;

    fsbc_state_rec_type s_r;
    fsbc_state_rec_type s_nxt;
    logic [7:0] mem_r [BYTES];
    fsbc_pkg::fsbc_cfg_type live_cfg;

    fsbc_lock_decode u_decode (
        .hardware_security_config_byte(s_r.hardware_security_config_byte),
        .cfg(live_cfg)
    );

    // ----------------------------------------
    // Synchronised programmer pins
    // ----------------------------------------
    logic [14:0] paddr_meta_r;
    logic [14:0] paddr_r;
    logic [7:0] pdata_meta_r;
    logic [7:0] pdata_r;
    always_ff @(posedge CLK_SYS) begin
        paddr_meta_r <= PROG_ADDR;
        paddr_r <= paddr_meta_r;
        pdata_meta_r <= PROG_WDATA;
        pdata_r <= pdata_meta_r;
    end

    logic strobe_rise;
    logic ea_low;
    logic level2;
    logic level3;
    assign strobe_rise = s_r.strb_meta[1] & ~s_r.strb_last;
    assign ea_low = ~s_r.ea_meta[1];
    assign level2 = s_r.cfg.security_level >= 3'h2;
    assign level3 = s_r.cfg.security_level >= 3'h3;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [AW-1:0] core_idx;
        logic ext_fetch;
        s_nxt = s_r;
        core_idx = CORE_ADDR[AW-1:0];
        s_nxt.cmd_meta = PROG_CMD;
        s_nxt.cmd_sync = s_r.cmd_meta;
        s_nxt.strb_meta = {1'b0, s_r.strb_meta[0], PROG_STROBE};
        s_nxt.ea_meta = {1'b0, s_r.ea_meta[0], EXT_ACCESS_N};
        s_nxt.strb_last = s_r.strb_meta[1];
        // Settle one cycle after reset so the decoder sees the stored byte
        if (!s_r.sampled) begin
            s_nxt.sampled = 1'b1;
            s_nxt.cfg = live_cfg;
            s_nxt.ea_latched = ea_low;
        end
        // Core fetch port answers in one cycle; no wait state
        ext_fetch = (s_r.cfg.security_level >= 3'h2 ? s_r.ea_latched : ea_low)
            | (CORE_ADDR >= 16'(BYTES));
        s_nxt.blocked = 1'b0;
        if (CORE_RD) begin
            if (CORE_TABLE_READ && CORE_FROM_EXT && level2) begin
                s_nxt.core_rdata = 8'hFF;
                s_nxt.blocked = 1'b1;
            end else if (ext_fetch && s_r.cfg.security_level == 3'h4) begin
                s_nxt.core_rdata = 8'hFF;
                s_nxt.blocked = 1'b1;
            end else begin
                s_nxt.core_rdata = mem_r[core_idx];
            end
        end
        // Programmer commands; lock bits never touch the API path
        if (strobe_rise && s_r.state == fsbc_pkg::FSBC_ST_IDLE) begin
            s_nxt.refused = 1'b0;
            s_nxt.tgt_addr = paddr_r[AW-1:0];
            s_nxt.tgt_data = pdata_r;
            s_nxt.tgt_page = 1'b0;
            s_nxt.tgt_chip = 1'b0;
            s_nxt.tgt_hsb = 1'b0;
            case (fsbc_pkg::fsbc_cmd_type'(s_r.cmd_sync))
                fsbc_pkg::FSBC_CMD_READ: begin
                    if (level3) begin
                        s_nxt.refused = 1'b1;
                        s_nxt.prog_rdata = 8'hFF;
                    end else begin
                        s_nxt.prog_rdata = mem_r[paddr_r[AW-1:0]];
                    end
                end
                fsbc_pkg::FSBC_CMD_PROG_BYTE, fsbc_pkg::FSBC_CMD_PROG_PAGE: begin
                    if (level2) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.tgt_page = s_r.cmd_sync == fsbc_pkg::FSBC_CMD_PROG_PAGE;
                        s_nxt.state = fsbc_pkg::FSBC_ST_BUSY;
                        s_nxt.timer = PROG_LOAD;
                    end
                end
                fsbc_pkg::FSBC_CMD_CHIP_ERASE: begin
                    s_nxt.tgt_chip = 1'b1;
                    s_nxt.state = fsbc_pkg::FSBC_ST_BUSY;
                    s_nxt.timer = PROG_LOAD;
                end
                fsbc_pkg::FSBC_CMD_READ_HSB: begin
                    s_nxt.prog_rdata = s_r.hardware_security_config_byte;
                end
                fsbc_pkg::FSBC_CMD_WRITE_HSB: begin
                    // Bits only move toward programmed; erase restores them
                    s_nxt.hsb_pending = s_r.hardware_security_config_byte & pdata_r;
                    s_nxt.tgt_hsb = 1'b1;
                    s_nxt.state = fsbc_pkg::FSBC_ST_BUSY;
                    s_nxt.timer = PROG_LOAD;
                end
                fsbc_pkg::FSBC_CMD_READ_ID: begin
                    s_nxt.prog_rdata = PART_ID;
                end
                default: begin
                    s_nxt.refused = 1'b0;
                end
            endcase
        end else if (API_WR && s_r.state == fsbc_pkg::FSBC_ST_IDLE) begin
            s_nxt.tgt_addr = API_ADDR[AW-1:0];
            s_nxt.tgt_data = API_WDATA;
            s_nxt.tgt_page = API_PAGE;
            s_nxt.tgt_chip = 1'b0;
            s_nxt.tgt_hsb = 1'b0;
            s_nxt.hsb_pending = s_r.hardware_security_config_byte;
            s_nxt.state = fsbc_pkg::FSBC_ST_BUSY;
            s_nxt.timer = PROG_LOAD;
        end
        case (s_r.state)
            fsbc_pkg::FSBC_ST_BUSY: begin
                if (s_r.timer == '0) begin
                    s_nxt.state = fsbc_pkg::FSBC_ST_IDLE;
                    if (s_r.tgt_chip) begin
                        s_nxt.hardware_security_config_byte = fsbc_pkg::HSB_ERASED;
                    end else begin
                        s_nxt.hardware_security_config_byte = s_r.hsb_pending;
                    end
                end else begin
                    s_nxt.timer = s_r.timer - 1'b1;
                end
            end
            default: begin
                // Keep a security write being launched this cycle
                if (s_nxt.state != fsbc_pkg::FSBC_ST_BUSY) begin
                    s_nxt.hsb_pending = s_r.hardware_security_config_byte;
                end
            end
        endcase
        if (!RSTN) begin
            s_nxt = '0;
            s_nxt.hardware_security_config_byte = s_r.hardware_security_config_byte;
            s_nxt.hsb_pending = s_r.hardware_security_config_byte;
            s_nxt.ea_meta = {1'b0, s_r.ea_meta[0], EXT_ACCESS_N};
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Power-up marker: the one flop with a start value, since reset must not touch it
    logic hsb_init_r = 1'b0;
    always_ff @(posedge CLK_SYS) begin
        s_r <= s_nxt;
        hsb_init_r <= 1'b1;
        // The security byte is nonvolatile: reset never clears it
        if (!hsb_init_r) begin
            s_r.hardware_security_config_byte <= fsbc_pkg::HSB_SHIPPED;
            s_r.hsb_pending <= fsbc_pkg::HSB_SHIPPED;
        end
    end

    // Self-erase folds into the write: new bytes replace old ones
    always_ff @(posedge CLK_SYS) begin
        // Security byte writes leave the array alone
        if (RSTN && s_r.state == fsbc_pkg::FSBC_ST_BUSY && s_r.timer == '0 && !s_r.tgt_hsb) begin
            for (int i = 0; i < BYTES; i++) begin
                if (s_r.tgt_chip) begin
                    mem_r[i] <= 8'hFF;
                end else if (s_r.tgt_page
                    && i[AW-1:7] == s_r.tgt_addr[AW-1:7]) begin
                    mem_r[i] <= s_r.tgt_data;
                end else if (!s_r.tgt_page && i[AW-1:0] == s_r.tgt_addr) begin
                    mem_r[i] <= s_r.tgt_data;
                end
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign PROG_RDATA = s_r.prog_rdata;
    assign PROG_BUSY = s_r.state == fsbc_pkg::FSBC_ST_BUSY;
    assign API_BUSY = s_r.state == fsbc_pkg::FSBC_ST_BUSY;
    assign PROG_REFUSED = s_r.refused;
    assign CORE_RDATA = s_r.core_rdata;
    assign CORE_BLOCKED = s_r.blocked;
    assign CORE_FETCH_EXT = (s_r.cfg.security_level >= 3'h2 ? s_r.ea_latched : ea_low)
        && s_r.cfg.security_level != 3'h4;
    assign DOUBLE_SPEED = s_r.cfg.double_speed_select;
    assign BOOT_ADDR = s_r.cfg.boot_user_app ? fsbc_pkg::BOOT_USER_ADDR : fsbc_pkg::BOOT_LOADER_ADDR;
    assign EXPANDED_RAM_INHIBIT = s_r.cfg.expanded_ram_inhibit;
    assign SECURITY_LEVEL = s_r.cfg.security_level;
endmodule : fsbc_top

// ==== hdl/fsbc_pkg.sv ====
// Package for the flash security and boot configuration block.
// Assumes a single core clock; no other package is needed.
package fsbc_pkg;
    // ----------------------------------------
    // Geometry and timing
    // ----------------------------------------
    localparam int PAGE_BYTES = 128;
    localparam int PAGES_16K = 128;
    localparam int PAGES_32K = 256;
    localparam int CLK_HZ = 20000000;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES = (CLK_HZ / 1000) * PROG_TIME_MS;
    localparam int TIMER_W = 18;
    // ----------------------------------------
    // Security byte layout
    // ----------------------------------------
    localparam int BIT_SPEED = 7;
    localparam int BIT_BOOT = 6;
    localparam int BIT_RAM = 3;
    localparam logic [7:0] HSB_SHIPPED = 8'hA8;
    localparam logic [7:0] HSB_ERASED = 8'hFF;
    localparam logic [15:0] BOOT_LOADER_ADDR = 16'hF800;
    localparam logic [15:0] BOOT_USER_ADDR = 16'h0000;
    // Arbitrary identification value, not tied to any real part
    localparam logic [7:0] PART_ID_DEFAULT = 8'h3C;
    // ----------------------------------------
    // Programmer commands and states
    // ----------------------------------------
    typedef enum logic [2:0] {
        FSBC_CMD_NONE = 3'h0,
        FSBC_CMD_READ = 3'h1,
        FSBC_CMD_PROG_BYTE = 3'h2,
        FSBC_CMD_PROG_PAGE = 3'h3,
        FSBC_CMD_CHIP_ERASE = 3'h4,
        FSBC_CMD_READ_HSB = 3'h5,
        FSBC_CMD_WRITE_HSB = 3'h6,
        FSBC_CMD_READ_ID = 3'h7
    } fsbc_cmd_type;
    typedef enum logic [1:0] {
        FSBC_ST_IDLE = 2'h0,
        FSBC_ST_BUSY = 2'h1
    } fsbc_state_type;
    typedef struct packed {
        logic double_speed_select;
        logic boot_user_app;
        logic expanded_ram_inhibit;
        logic [2:0] security_level;
    } fsbc_cfg_type;
endpackage : fsbc_pkg

// ==== hdl/fsbc_lock_decode.sv ====
// Decoder from security byte to live configuration.
// Assumes the byte arrives from logic on the same clock.
`timescale 1ns/100ps
module fsbc_lock_decode (
    input wire logic [7:0] hardware_security_config_byte,
    output fsbc_pkg::fsbc_cfg_type cfg
);
    always_comb begin
        cfg.double_speed_select = ~hardware_security_config_byte[fsbc_pkg::BIT_SPEED];
        cfg.boot_user_app = hardware_security_config_byte[fsbc_pkg::BIT_BOOT];
        cfg.expanded_ram_inhibit = ~hardware_security_config_byte[fsbc_pkg::BIT_RAM];
        // Programmed reads zero; highest programmed bit wins
        if (!hardware_security_config_byte[2]) begin
            cfg.security_level = 3'h4;
        end else if (!hardware_security_config_byte[1]) begin
            cfg.security_level = 3'h3;
        end else if (!hardware_security_config_byte[0]) begin
            cfg.security_level = 3'h2;
        end else begin
            cfg.security_level = 3'h1;
        end
    end
endmodule : fsbc_lock_decode

// ==== testbench/fsbc_top_asserts.sv ====
// Checker for the flash security block, bound to the top module.
// Assumes fsbc_pkg is compiled first and sees only the top module ports.
`timescale 1ns/100ps
module fsbc_top_asserts #(
    parameter int PROG_CYCLES = fsbc_pkg::PROG_CYCLES,
    parameter logic [7:0] PART_ID = fsbc_pkg::PART_ID_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic EXT_ACCESS_N,
    input wire logic [2:0] PROG_CMD,
    input wire logic PROG_STROBE,
    input wire logic [7:0] PROG_RDATA,
    input wire logic PROG_BUSY,
    input wire logic PROG_REFUSED,
    input wire logic CORE_RD,
    input wire logic CORE_TABLE_READ,
    input wire logic CORE_FROM_EXT,
    input wire logic [7:0] CORE_RDATA,
    input wire logic CORE_FETCH_EXT,
    input wire logic CORE_BLOCKED,
    input wire logic API_WR,
    input wire logic DOUBLE_SPEED,
    input wire logic [15:0] BOOT_ADDR,
    input wire logic EXPANDED_RAM_INHIBIT,
    input wire logic [2:0] SECURITY_LEVEL
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Counts busy cycles; cleared when idle so each run is measured alone
    logic [31:0] busy_cnt_r;
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN || !PROG_BUSY) begin
            busy_cnt_r <= 32'h0000_0000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
        end
    end
    sequence s_take(logic [2:0] c);
        $rose(PROG_STROBE) && PROG_CMD == c;
    endsequence
    sequence s_tbl_ext;
        CORE_RD && CORE_TABLE_READ && CORE_FROM_EXT;
    endsequence
    sequence s_ext_low;
        (!EXT_ACCESS_N && SECURITY_LEVEL == 3'h1) [*5];
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_busy_len;
        $fell(PROG_BUSY) |-> busy_cnt_r == PROG_CYCLES;
    endproperty
    property p_api_start;
        API_WR && !PROG_BUSY && !PROG_STROBE |-> ##[1:2] PROG_BUSY;
    endproperty
    property p_tbl_block;
        s_tbl_ext ##0 SECURITY_LEVEL >= 3'h2 |=> CORE_BLOCKED && CORE_RDATA == 8'hFF;
    endproperty
    property p_lvl1_open;
        CORE_RD && SECURITY_LEVEL == 3'h1 |=> !CORE_BLOCKED;
    endproperty
    property p_cfg_hold;
        $past(RSTN) && $past(RSTN, 2) && $past(RSTN, 3)
            |-> $stable({DOUBLE_SPEED, BOOT_ADDR, EXPANDED_RAM_INHIBIT, SECURITY_LEVEL});
    endproperty
    property p_no_ext_l4;
        SECURITY_LEVEL == 3'h4 |-> !CORE_FETCH_EXT;
    endproperty
    property p_ext_fetch;
        s_ext_low |-> CORE_FETCH_EXT;
    endproperty
    property p_prog_refuse;
        s_take(fsbc_pkg::FSBC_CMD_PROG_BYTE) ##0 SECURITY_LEVEL >= 3'h2 |-> ##[1:8] PROG_REFUSED;
    endproperty
    property p_verify_refuse;
        s_take(fsbc_pkg::FSBC_CMD_READ) ##0 SECURITY_LEVEL >= 3'h3 |-> ##[1:8] (PROG_REFUSED && PROG_RDATA == 8'hFF);
    endproperty
    property p_id_read;
        s_take(fsbc_pkg::FSBC_CMD_READ_ID) |-> ##[1:8] (PROG_RDATA == PART_ID && !PROG_REFUSED);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_api_start: assert property (p_api_start) else $error("api write did not start");
    a_tbl_block: assert property (p_tbl_block) else $error("table read not blocked");
    a_lvl1_open: assert property (p_lvl1_open) else $error("read blocked at level one");
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved between resets");
    a_no_ext_l4: assert property (p_no_ext_l4) else $error("external fetch at level four");
    a_ext_fetch: assert property (p_ext_fetch) else $error("external fetch not selected");
    a_prog_refuse: assert property (p_prog_refuse) else $error("program not refused");
    a_verify_refuse: assert property (p_verify_refuse) else $error("verify not refused");
    a_id_read: assert property (p_id_read) else $error("part id wrong");
endmodule : fsbc_top_asserts
bind fsbc_top fsbc_top_asserts #(.PROG_CYCLES(PROG_CYCLES), .PART_ID(PART_ID)) i_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .EXT_ACCESS_N(EXT_ACCESS_N), .PROG_CMD(PROG_CMD),
    .PROG_STROBE(PROG_STROBE), .PROG_RDATA(PROG_RDATA), .PROG_BUSY(PROG_BUSY), .PROG_REFUSED(PROG_REFUSED),
    .CORE_RD(CORE_RD), .CORE_TABLE_READ(CORE_TABLE_READ), .CORE_FROM_EXT(CORE_FROM_EXT),
    .CORE_RDATA(CORE_RDATA), .CORE_FETCH_EXT(CORE_FETCH_EXT), .CORE_BLOCKED(CORE_BLOCKED),
    .API_WR(API_WR), .DOUBLE_SPEED(DOUBLE_SPEED), .BOOT_ADDR(BOOT_ADDR),
    .EXPANDED_RAM_INHIBIT(EXPANDED_RAM_INHIBIT), .SECURITY_LEVEL(SECURITY_LEVEL)
);

// ==== testbench/fsbc_prog_model.sv ====
// Parallel programmer model driving the programmer pins.
// Assumes the device synchronises the pins on the same clock it is given.
`timescale 1ns/100ps
module fsbc_prog_model (
    input wire logic clk_sys,
    output logic [2:0] prog_cmd,
    output logic prog_strobe,
    output logic [14:0] prog_addr,
    output logic [7:0] prog_wdata,
    input wire logic [7:0] prog_rdata,
    input wire logic prog_busy,
    input wire logic prog_refused
);
    initial begin
        prog_cmd = fsbc_pkg::FSBC_CMD_NONE;
        prog_strobe = 1'b0;
        prog_addr = 15'h0000;
        prog_wdata = 8'h00;
    end
    // Fields settle three cycles before the strobe so the pin sync sees them
    task automatic run(input logic [2:0] cmd, input logic [14:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata, output logic refused, output logic ok);
        int n;
        @(posedge clk_sys);
        prog_cmd <= cmd;
        prog_addr <= addr;
        prog_wdata <= wdata;
        repeat (3) @(posedge clk_sys);
        prog_strobe <= 1'b1;
        repeat (6) @(posedge clk_sys);
        n = 0;
        while (prog_busy !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        ok = (n < 100);
        rdata = prog_rdata;
        refused = prog_refused;
        // Released address and data show the inverse so stale values cannot pass
        prog_strobe <= 1'b0;
        prog_cmd <= fsbc_pkg::FSBC_CMD_NONE;
        prog_addr <= ~addr;
        prog_wdata <= ~wdata;
        repeat (3) @(posedge clk_sys);
    endtask : run
endmodule : fsbc_prog_model

// ==== testbench/tb.sv ====
// Testbench for the flash security block: programmer, core and API traffic.
// Assumes package, design, programmer model and checker are compiled first.
`timescale 1ns/100ps
module tb;
    localparam int PCYC = 8;
    logic clk_sys;
    logic rstn = 1'b0;
    logic ext_n = 1'b1;
    logic core_rd = 1'b0;
    logic core_tbl = 1'b0;
    logic core_ext = 1'b0;
    logic [15:0] core_addr = 16'h0000;
    logic api_wr = 1'b0;
    logic api_page = 1'b0;
    logic [14:0] api_addr = 15'h0000;
    logic [7:0] api_wdata = 8'h00;
    logic [2:0] cmd, lvl;
    logic strobe, busy, refused, fetch_ext, blocked, api_busy, dbl, ram_inh, ref_seen, ok;
    logic [14:0] paddr;
    logic [7:0] pwdata, prdata, core_rdata, rd;
    logic [15:0] boot;
    int err_count = 0;
    int checks = 0;
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    fsbc_top #(.PROG_CYCLES(PCYC)) i_dut (
        .CLK_SYS(clk_sys), .RSTN(rstn), .EXT_ACCESS_N(ext_n), .PROG_CMD(cmd), .PROG_STROBE(strobe),
        .PROG_ADDR(paddr), .PROG_WDATA(pwdata), .PROG_RDATA(prdata), .PROG_BUSY(busy), .PROG_REFUSED(refused),
        .CORE_RD(core_rd), .CORE_TABLE_READ(core_tbl), .CORE_FROM_EXT(core_ext), .CORE_ADDR(core_addr),
        .CORE_RDATA(core_rdata), .CORE_FETCH_EXT(fetch_ext), .CORE_BLOCKED(blocked), .API_WR(api_wr),
        .API_PAGE(api_page), .API_ADDR(api_addr), .API_WDATA(api_wdata), .API_BUSY(api_busy),
        .DOUBLE_SPEED(dbl), .BOOT_ADDR(boot), .EXPANDED_RAM_INHIBIT(ram_inh), .SECURITY_LEVEL(lvl)
    );
    fsbc_prog_model i_prog (
        .clk_sys(clk_sys), .prog_cmd(cmd), .prog_strobe(strobe), .prog_addr(paddr),
        .prog_wdata(pwdata), .prog_rdata(prdata), .prog_busy(busy), .prog_refused(refused)
    );
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset();
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : do_reset
    task automatic prog(input fsbc_pkg::fsbc_cmd_type c, input logic [14:0] a, input logic [7:0] d);
        i_prog.run(c, a, d, rd, ref_seen, ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1) begin
            end_of_test();
        end
    endtask : prog
    task automatic core(input logic [15:0] a, input logic t, input logic e, input logic [7:0] d, input logic b);
        @(posedge clk_sys);
        core_rd <= 1'b1;
        core_addr <= a;
        core_tbl <= t;
        core_ext <= e;
        @(posedge clk_sys);
        core_rd <= 1'b0;
        #1;
        chk(core_rdata, d);
        chk(blocked, b);
    endtask : core
    // Byte or page program by software; busy must rise and then clear within bound
    task automatic api(input logic [14:0] a, input logic [7:0] d, input logic p);
        int n;
        @(posedge clk_sys);
        api_wr <= 1'b1;
        api_page <= p;
        api_addr <= a;
        api_wdata <= d;
        @(posedge clk_sys);
        api_wr <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(api_busy, 1'b1);
        n = 0;
        while (api_busy !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n < 100, 1'b1);
        if (n >= 100) begin
            end_of_test();
        end
    endtask : api
    task automatic cfg(input logic d, input logic [15:0] b, input logic r, input logic [2:0] l);
        chk(dbl, d);
        chk(boot, b);
        chk(ram_inh, r);
        chk(lvl, l);
    endtask : cfg
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        cfg(1'b0, 16'hF800, 1'b0, 3'h4);
        prog(fsbc_pkg::FSBC_CMD_READ_ID, 15'h0000, 8'h00);
        chk(rd, fsbc_pkg::PART_ID_DEFAULT);
        prog(fsbc_pkg::FSBC_CMD_READ_HSB, 15'h0000, 8'h00);
        chk(rd, fsbc_pkg::HSB_SHIPPED);
        prog(fsbc_pkg::FSBC_CMD_READ, 15'h0005, 8'h00);
        chk({ref_seen, rd}, 9'h1FF);
        prog(fsbc_pkg::FSBC_CMD_PROG_BYTE, 15'h0005, 8'h00);
        chk(ref_seen, 1'b1);
        core(16'h0005, 1'b1, 1'b1, 8'hFF, 1'b1);
        prog(fsbc_pkg::FSBC_CMD_CHIP_ERASE, 15'h0000, 8'h00);
        prog(fsbc_pkg::FSBC_CMD_READ_HSB, 15'h0000, 8'h00);
        chk(rd, fsbc_pkg::HSB_ERASED);
        cfg(1'b0, 16'hF800, 1'b0, 3'h4);
        do_reset();
        cfg(1'b0, 16'h0000, 1'b0, 3'h1);
        core(16'h0000, 1'b1, 1'b1, 8'hFF, 1'b0);
        prog(fsbc_pkg::FSBC_CMD_PROG_BYTE, 15'h0005, 8'h5A);
        prog(fsbc_pkg::FSBC_CMD_PROG_BYTE, 15'h0005, 8'hA5);
        prog(fsbc_pkg::FSBC_CMD_READ, 15'h0005, 8'h00);
        chk(rd, 8'hA5);
        core(16'h0005, 1'b0, 1'b0, 8'hA5, 1'b0);
        api(15'h0100, 8'h33, 1'b1);
        core(16'h0100, 1'b0, 1'b0, 8'h33, 1'b0);
        core(16'h017F, 1'b0, 1'b0, 8'h33, 1'b0);
        core(16'h0180, 1'b0, 1'b0, 8'hFF, 1'b0);
        core(16'h00FF, 1'b0, 1'b0, 8'hFF, 1'b0);
        ext_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(fetch_ext, 1'b1);
        ext_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(fetch_ext, 1'b0);
        prog(fsbc_pkg::FSBC_CMD_WRITE_HSB, 15'h0000, 8'h76);
        prog(fsbc_pkg::FSBC_CMD_READ_HSB, 15'h0000, 8'h00);
        chk(rd, 8'h76);
        cfg(1'b0, 16'h0000, 1'b0, 3'h1);
        do_reset();
        cfg(1'b1, 16'h0000, 1'b1, 3'h2);
        prog(fsbc_pkg::FSBC_CMD_READ, 15'h0005, 8'h00);
        chk({ref_seen, rd}, 9'h0A5);
        prog(fsbc_pkg::FSBC_CMD_PROG_BYTE, 15'h0005, 8'h00);
        chk(ref_seen, 1'b1);
        api(15'h0200, 8'h11, 1'b0);
        core(16'h0200, 1'b0, 1'b0, 8'h11, 1'b0);
        core(16'h0201, 1'b0, 1'b0, 8'hFF, 1'b0);
        ext_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(fetch_ext, 1'b0);
        ext_n <= 1'b1;
        prog(fsbc_pkg::FSBC_CMD_WRITE_HSB, 15'h0000, 8'h74);
        do_reset();
        chk(lvl, 3'h3);
        prog(fsbc_pkg::FSBC_CMD_READ, 15'h0005, 8'h00);
        chk({ref_seen, rd}, 9'h1FF);
        prog(fsbc_pkg::FSBC_CMD_READ_ID, 15'h0000, 8'h00);
        chk(rd, fsbc_pkg::PART_ID_DEFAULT);
        end_of_test();
    end
endmodule : tb
